// [hw/cic_core_irq_ctrl.sv]
/*
  Core interrupt control register with AXI4-Lite access, sticky event status
  with mask, and the interrupt request toward the processor core.
  Assumes timer_overflow and periph_irq_req come from logic on aclk, and
  that the pins are asynchronous. All state freezes while ce is low.
*/

module cic_core_irq_ctrl
  import cic_pkg::*;
#(
  parameter int PORT_W = 4
)
(
  // Clock, reset and clock enable.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // AXI4-Lite write address.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data.
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data.
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Interrupt sources.
  input  wire logic              timer_overflow,
  input  wire logic              external_interrupt_pin,
  input  wire logic [PORT_W-1:0] port_change_pins,
  input  wire logic              periph_irq_req,
  // Interrupt outputs.
  output logic                   irq_to_core,
  output logic                   sys_irq
);

  cic_evt_if evt ();

  logic [REG_W-1:0]  intctl_r;
  logic [REG_W-1:0]  intctl_nxt;
  logic [EVT_N-1:0]  status_r;
  logic [EVT_N-1:0]  status_nxt;
  logic [EVT_N-1:0]  mask_r;
  logic              cfg_rising_r;
  logic [EVT_N-1:0]  event_vec;
  logic              aw_held_r;
  logic              w_held_r;
  logic [IDX_W-1:0]  aw_idx_r;
  logic [7:0]        w_byte_r;
  logic              w_strb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [DATA_W-1:0] rdata_r;
  logic              irq_core_r;
  logic              sys_irq_r;
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              wr_go;
  logic              wr_intctl;
  logic              wr_status;
  logic              wr_mask;
  logic              wr_cfg;
  logic              wr_hit;
  logic [IDX_W-1:0]  ar_idx;
  logic [DATA_W-1:0] rd_val;
  logic              rd_hit;

  cic_event_capture #(
    .PORT_W (PORT_W)
  ) u_capture (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .ce                     (ce),
    .external_interrupt_pin (external_interrupt_pin),
    .port_change_pins       (port_change_pins),
    .evt                    (evt.capture)
  );

  assign evt.ext_edge_rising = cfg_rising_r;

  always_comb
  begin
    event_vec            = '0;
    event_vec[EVT_TIMER] = timer_overflow & ce;
    event_vec[EVT_EXT]   = evt.ext_evt;
    event_vec[EVT_PORT]  = evt.port_evt;
  end

  // Bus handshakes; address and data are taken in either order.
  assign s_axi_awready = ce & ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ce & ~w_held_r & ~bvalid_r;
  assign s_axi_arready = ce & ~rvalid_r;
  assign aw_hs         = s_axi_awvalid & s_axi_awready;
  assign w_hs          = s_axi_wvalid & s_axi_wready;
  assign ar_hs         = s_axi_arvalid & s_axi_arready;
  assign wr_go         = ce & aw_held_r & w_held_r & ~bvalid_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      aw_idx_r  <= '0;
    end
    else if (ce)
    begin
      if (aw_hs)
      begin
        aw_held_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr[ADDR_W-1:IDX_LSB];
      end
      else if (wr_go)
      begin
        aw_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_r <= 1'b0;
      w_byte_r <= '0;
      w_strb_r <= 1'b0;
    end
    else if (ce)
    begin
      if (w_hs)
      begin
        w_held_r <= 1'b1;
        w_byte_r <= s_axi_wdata[REG_W-1:0];
        w_strb_r <= s_axi_wstrb[0];
      end
      else if (wr_go)
      begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Write decode; all four bank addresses select one register.
  always_comb
  begin
    wr_intctl = 1'b0;
    wr_status = 1'b0;
    wr_mask   = 1'b0;
    wr_cfg    = 1'b0;
    if (aw_idx_r == IDX_INTCTL_BANK0 || aw_idx_r == IDX_INTCTL_BANK1 ||
        aw_idx_r == IDX_INTCTL_BANK2 || aw_idx_r == IDX_INTCTL_BANK3)
      wr_intctl = 1'b1;
    else if (aw_idx_r == IDX_EVT_STATUS)
      wr_status = 1'b1;
    else if (aw_idx_r == IDX_EVT_MASK)
      wr_mask = 1'b1;
    else if (aw_idx_r == IDX_CONFIG)
      wr_cfg = 1'b1;
    wr_hit = wr_intctl | wr_status | wr_mask | wr_cfg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // A software write and an event in the same cycle: the event wins.
  always_comb
  begin
    intctl_nxt = intctl_r;
    if (wr_go && wr_intctl && w_strb_r)
      intctl_nxt = w_byte_r;
    intctl_nxt[FLG_LSB +: EVT_N] = intctl_nxt[FLG_LSB +: EVT_N] | event_vec;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      intctl_r <= INTCTL_RST;
    else if (ce)
      intctl_r <= intctl_nxt;
  end

  // Sticky status, cleared by writing one; a new event wins over the clear.
  always_comb
  begin
    status_nxt = status_r;
    if (wr_go && wr_status && w_strb_r)
      status_nxt = status_r & ~w_byte_r[EVT_N-1:0];
    status_nxt = status_nxt | event_vec;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_r     <= EVT_RST;
      mask_r       <= EVT_RST;
      cfg_rising_r <= CFG_RISING_RST;
    end
    else if (ce)
    begin
      status_r <= status_nxt;
      if (wr_go && wr_mask && w_strb_r)
        mask_r <= w_byte_r[EVT_N-1:0];
      if (wr_go && wr_cfg && w_strb_r)
        cfg_rising_r <= w_byte_r[BIT_EXT_RISING];
    end
  end

  // Read decode.
  assign ar_idx = s_axi_araddr[ADDR_W-1:IDX_LSB];

  always_comb
  begin
    rd_val = '0;
    rd_hit = 1'b1;
    if (ar_idx == IDX_INTCTL_BANK0 || ar_idx == IDX_INTCTL_BANK1 ||
        ar_idx == IDX_INTCTL_BANK2 || ar_idx == IDX_INTCTL_BANK3)
      rd_val[REG_W-1:0] = intctl_r;
    else if (ar_idx == IDX_EVT_STATUS)
      rd_val[EVT_N-1:0] = status_r;
    else if (ar_idx == IDX_EVT_MASK)
      rd_val[EVT_N-1:0] = mask_r;
    else if (ar_idx == IDX_CONFIG)
      rd_val[BIT_EXT_RISING] = cfg_rising_r;
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
    end
    else if (ce)
    begin
      if (ar_hs)
      begin
        rvalid_r <= 1'b1;
        rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_r  <= rd_val;
      end
      else if (s_axi_rready)
      begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Request toward the processor core.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_core_r <= 1'b0;
    else if (ce)
      irq_core_r <= intctl_r[BIT_GIE] &
                    (|(intctl_r[ENA_LSB +: EVT_N] & intctl_r[FLG_LSB +: EVT_N]) |
                     (intctl_r[BIT_PERIPHERAL_GROUP_ENABLE] & periph_irq_req));
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sys_irq_r <= 1'b0;
    else if (ce)
      sys_irq_r <= |(status_r & mask_r);
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;
  assign irq_to_core  = irq_core_r;
  assign sys_irq      = sys_irq_r;

endmodule

// [hw/cic_event_capture.sv]
/*
  Synchronises the external interrupt pin and the port-change pins and turns
  them into one-cycle event pulses.
  Assumes pins are asynchronous to aclk; all state freezes while ce is low.
*/
module cic_event_capture
  import cic_pkg::*;
#(
  parameter int PORT_W = 4
)
(
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // Raw pins.
  input  wire logic              external_interrupt_pin,
  input  wire logic [PORT_W-1:0] port_change_pins,
  // Events toward the core.
  cic_evt_if.capture             evt
);

  logic [PORT_W:0] meta_r;
  logic [PORT_W:0] sync_r;
  logic [PORT_W:0] last_r;
  logic [PORT_W:0] raw;
  localparam int   FILL_N = 3;

  logic [FILL_N-1:0] fill_r;
  logic            ext_evt_r;
  logic            port_evt_r;

  assign raw = {external_interrupt_pin, port_change_pins};

  // Two flops per pin; the third stage feeds only edge detection.
  genvar g;
  generate
    for (g = 0; g <= PORT_W; g++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
          last_r[g] <= 1'b0;
        end
        else if (ce)
        begin
          meta_r[g] <= raw[g];
          sync_r[g] <= meta_r[g];
          last_r[g] <= sync_r[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_evt_r  <= 1'b0;
      port_evt_r <= 1'b0;
      fill_r     <= '0;
    end
    else if (ce)
    begin
      // Edges count only once both compared stages hold real pin samples,
      // so a pin already high when reset ends raises no false event.
      fill_r     <= {fill_r[FILL_N-2:0], 1'b1};
      // The selected edge of the external pin is the event.
      ext_evt_r  <= fill_r[FILL_N-1] &
                    (evt.ext_edge_rising ? (sync_r[PORT_W] & ~last_r[PORT_W])
                                         : (~sync_r[PORT_W] & last_r[PORT_W]));
      // Any port pin differing from its previous sample is a change.
      port_evt_r <= fill_r[FILL_N-1] & (|(sync_r[PORT_W-1:0] ^ last_r[PORT_W-1:0]));
    end
  end

  assign evt.ext_evt  = ext_evt_r & ce;
  assign evt.port_evt = port_evt_r & ce;

endmodule

// [pkg/cic_evt_if.sv]
/*
  Carrier between the event capture module and the register core.
  Assumes both ends run on the same clock.
*/
interface cic_evt_if;
  logic ext_edge_rising;
  logic ext_evt;
  logic port_evt;

  modport capture (input ext_edge_rising, output ext_evt, output port_evt);
  modport core    (output ext_edge_rising, input ext_evt, input port_evt);
endinterface

// [pkg/cic_pkg.sv]
/*
  Constants for the core interrupt control block: register indexes, field
  positions, reset values and bus response codes.
  Assumes a 32-bit AXI4-Lite bus where byte address = 4 * register index.
*/
package cic_pkg;

  // Bus geometry.
  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 32;
  localparam int          IDX_W      = 10;
  localparam int          IDX_LSB    = 2;

  // Register indexes; byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_INTCTL_BANK0 = 10'h00B;
  localparam logic [IDX_W-1:0] IDX_INTCTL_BANK1 = 10'h08B;
  localparam logic [IDX_W-1:0] IDX_INTCTL_BANK2 = 10'h10B;
  localparam logic [IDX_W-1:0] IDX_INTCTL_BANK3 = 10'h18B;
  localparam logic [IDX_W-1:0] IDX_EVT_STATUS   = 10'h00C;
  localparam logic [IDX_W-1:0] IDX_EVT_MASK     = 10'h00D;
  localparam logic [IDX_W-1:0] IDX_CONFIG       = 10'h00E;

  // Interrupt control register layout.
  localparam int          REG_W      = 8;
  localparam int          EVT_N      = 3;
  localparam int          BIT_GIE    = 7;
  localparam int          BIT_PERIPHERAL_GROUP_ENABLE   = 6;
  localparam int          ENA_LSB    = 3;
  localparam int          FLG_LSB    = 0;

  // Event positions, shared by flags, enables, status and mask.
  localparam int          EVT_TIMER  = 2;
  localparam int          EVT_EXT    = 1;
  localparam int          EVT_PORT   = 0;

  // Configuration register layout.
  localparam int          BIT_EXT_RISING = 0;

  // Reset values.
  localparam logic [REG_W-1:0] INTCTL_RST = 8'h00;
  localparam logic [EVT_N-1:0] EVT_RST    = 3'h0;
  localparam logic             CFG_RISING_RST = 1'b1;

  // AXI responses.
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// [tb/cic_core_irq_ctrl_chk.sv]
/*
  Checker for the core interrupt control block.
  Sees only the top module's ports; bound below.
*/
module cic_core_irq_ctrl_chk
  import cic_pkg::*;
(
  // Clock and reset.
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              ce,
  // Register bus.
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Interrupts.
  input wire logic              irq_to_core,
  input wire logic              sys_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wrote_r;
  // Remembers that some write has completed since reset.
  always_ff @(posedge aclk)
    if (!aresetn) wrote_r <= 1'b0;
    else if (s_axi_bvalid) wrote_r <= 1'b1;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bvalid_holds: assert property (s_axi_bvalid && !(s_axi_bready && ce) |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !(s_axi_rready && ce)
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  // The write is applied and bvalid rises one edge after both halves are taken; the check samples bvalid at the next.
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_gie_reset: assert property (!wrote_r |-> !irq_to_core)
    else $error("core request with global enable clear");
  a_mask_reset: assert property (!wrote_r |-> !sys_irq)
    else $error("system interrupt with mask clear");
endmodule

bind cic_core_irq_ctrl cic_core_irq_ctrl_chk chk_u (
  .aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .irq_to_core(irq_to_core), .sys_irq(sys_irq)
);

// [tb/cic_core_model.sv]
/*
  Model of the processor core that takes the interrupt request.
  Assumes the request is a level on aclk.
*/
module cic_core_model
#(
  parameter int LAT = 2
)
(
  // Clock and reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  // Request and acceptance.
  input  wire logic irq_to_core,
  output logic      irq_taken
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_r;
  // The core takes the request only once it has stood for LAT cycles.
  always_ff @(posedge aclk)
    if (!aresetn || !irq_to_core) cnt_r <= 0;
    else if (cnt_r < LAT) cnt_r <= cnt_r + 1;
  assign irq_taken = (cnt_r == LAT);
endmodule

// [tb/tb.sv]
/*
  Self-checking bench for the core interrupt control block.
  Assumes a 25 MHz clock and byte address = 4 * register index.
*/
module tb
  import cic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] bk [4] = '{{IDX_INTCTL_BANK0, 2'b00}, {IDX_INTCTL_BANK1, 2'b00},
                                     {IDX_INTCTL_BANK2, 2'b00}, {IDX_INTCTL_BANK3, 2'b00}};
  // Each row: control value, peripheral request, expected core request.
  localparam logic [9:0] rows [9] = '{10'h210, 10'h291, 10'h090, 10'h244, 10'h249,
                                      10'h225, 10'h202, 10'h303, 10'h102};
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, tmr = 0, ext = 0, per = 0, ce = 1;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rdv;
  logic [3:0]  port = 0;
  logic [1:0]  bresp, rresp, rsp;
  logic        awready, wready, bvalid, arready, rvalid, irq, sys, taken;
  int          fails = 0, checks_done = 0;

  always #20 aclk = ~aclk;

  cic_core_irq_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_overflow(tmr), .external_interrupt_pin(ext), .port_change_pins(port),
    .periph_irq_req(per), .irq_to_core(irq), .sys_irq(sys));
  cic_core_model #(.LAT(3)) core_u (.aclk(aclk), .aresetn(aresetn), .irq_to_core(irq),
    .irq_taken(taken));

  task automatic close_out();
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit ad, dd;
    ad = 0;
    dd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        dd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rdv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(bk[0]);
    chk(rdv, 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      per <= rows[i][1];
      wr(bk[i % 4], {24'h0, rows[i][9:2]});
      rd(bk[(i + 1) % 4]);
      chk(rdv, {24'h0, rows[i][9:2]});
      chk(32'(irq), 32'(rows[i][0]));
      repeat (3) @(posedge aclk);
      chk(32'(taken), 32'(rows[i][0]));
    end
    per <= 1'b0;
    wr(bk[0], 32'h0);
    tmr <= 1'b1;
    @(posedge aclk);
    tmr <= 1'b0;
    rd(bk[1]);
    chk(rdv, 32'h04);
    wr(bk[0], 32'h0);
    ext <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(bk[2]);
    chk(rdv, 32'h02);
    repeat (20) @(posedge aclk);
    port <= 4'h1;
    repeat (8) @(posedge aclk);
    rd(bk[3]);
    chk(rdv, 32'h03);
    wr({IDX_EVT_MASK, 2'b00}, 32'h4);
    repeat (3) @(posedge aclk);
    chk(32'(sys), 32'h1);
    wr({IDX_EVT_STATUS, 2'b00}, 32'h4);
    repeat (3) @(posedge aclk);
    chk(32'(sys), 32'h0);
    rd(12'h100);
    chk(rdv, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(12'h100, 32'hFF);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(bk[1], 32'h0);
    rd(bk[0]);
    chk(rdv, 32'h0);
    // A timer pulse while the clock enable is low must leave no trace.
    ce <= 1'b0;
    tmr <= 1'b1;
    @(posedge aclk);
    tmr <= 1'b0;
    ce <= 1'b1;
    rd(bk[2]);
    chk(rdv, 32'h0);
    // Falling-edge mode of the external pin.
    rd({IDX_CONFIG, 2'b00});
    chk(rdv, 32'h1);
    wr({IDX_CONFIG, 2'b00}, 32'h0);
    ext <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(bk[3]);
    chk(rdv, 32'h02);
    // Reset in mid-run with pins high: no false events after release.
    ext <= 1'b1;
    port <= 4'hF;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(bk[0]);
    chk(rdv, 32'h0);
    rd({IDX_CONFIG, 2'b00});
    chk(rdv, 32'h1);
    close_out();
  end

  initial
  begin
    repeat (5000) @(posedge aclk);
    fails++;
    close_out();
  end
endmodule
